// ==== design/sfp_defines.vh ====
// Purpose: shared constants for the failure-prediction command block
// Assumes: task-file byte addresses as the host sees them
// Notes: timing counts are cycles of the 250 MHz controller clock
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH
// task-file addresses
`define SFP_ADDR_FEAT 10'h1f1
`define SFP_ADDR_SCNT 10'h1f2
`define SFP_ADDR_SNUM 10'h1f3
`define SFP_ADDR_CYLL 10'h1f4
`define SFP_ADDR_CYLH 10'h1f5
`define SFP_ADDR_DHS 10'h1f6
`define SFP_ADDR_CMD 10'h1f7
// command and subcommand codes
`define SFP_CMD_SMART 8'hb0
`define SFP_SUB_RD_ATTR 8'hd0
`define SFP_SUB_RD_THR 8'hd1
`define SFP_SUB_AUTOSAVE 8'hd2
`define SFP_SUB_SAVE 8'hd3
`define SFP_SUB_ENABLE 8'hd8
`define SFP_SUB_DISABLE 8'hd9
`define SFP_SUB_STATUS 8'hda
// keys and verdicts
`define SFP_KEY_LOW 8'h4f
`define SFP_KEY_HIGH 8'hc2
`define SFP_FAIL_LOW 8'hf4
`define SFP_FAIL_HIGH 8'h2c
// status bits and fault code
`define SFP_ST_BUSY 7
`define SFP_ST_READY 6
`define SFP_ST_DRQ 3
`define SFP_ST_ERR 0
`define SFP_ST_IDLE 8'h40
`define SFP_FAULT_ABORT 8'h04
// data block size in bytes
`define SFP_BLOCK_BYTES 10'h200
// per-attribute comparison, in one module
`define SFP_ATTR_COUNT 30
`endif

// ==== design/sfp_attr_cmp.v ====
// Purpose: compare each attribute value against its threshold
// Assumes: attributes packed 8 bits each, slot 0 in the low byte
// Notes: a zero threshold marks an unused slot and never trips
`timescale 1ns/100ps
module sfp_attr_cmp #(
	parameter N = 30
) (
	input wire [8*N-1:0] value_i, // current normalised values
	input wire [8*N-1:0] thresh_i, // failure thresholds
	output wire crossed_o // any value at or below a nonzero threshold
);
	wire [N-1:0] hit;
	genvar g;
	// a value not above its nonzero threshold counts as crossed
	generate
		for (g = 0; g < N; g = g + 1) begin : slot
			assign hit[g] = (thresh_i[8*g+7:8*g] != 8'h00) &&
				(value_i[8*g+7:8*g] <= thresh_i[8*g+7:8*g]);
		end
	endgenerate
	assign crossed_o = |hit;
endmodule

// ==== design/sfp_cmd.v ====
// Purpose: failure-prediction command handling behind the task file
// Assumes: host strobes are one cycle wide and synchronous to clock_i
// Notes: medium and nonvolatile store are reached through handshakes
// Notes: the settings pair {autosave, prediction} lives outside this block;
// Notes: it is read back once after every reset release, so a reset acts as
// Notes: a power cycle as far as the two persistent settings are concerned
// Notes: busy drops no later than the data phase of a block read begins; drq marks
// Notes: the phase, so the host can poll status while bytes are offered
`timescale 1ns/100ps
`include "sfp_defines.vh"
module sfp_cmd #(
	parameter N_ATTR = `SFP_ATTR_COUNT,
	parameter BLOCK_BYTES = 512
) (
	input wire clock_i, // 250 MHz controller clock
	input wire arst_n_i, // async reset, active low
	input wire [9:0] addr_i, // task-file address
	input wire wr_i, // host write strobe
	input wire rd_i, // host read strobe
	input wire [7:0] wdata_i, // host write data
	output reg [7:0] rdata_o, // read data, valid cycle after rd_i
	output reg irq_o, // completion interrupt, cleared by status read
	output reg data_valid_o, // data byte ready for host
	output reg [7:0] data_o, // data byte to host
	input wire data_ack_i, // host took the data byte
	output reg save_req_o, // request attribute save to medium
	input wire save_done_i, // medium save finished
	output reg nv_wr_o, // request nonvolatile write
	output reg [1:0] nv_data_o, // {autosave, prediction}
	input wire nv_done_i, // nonvolatile write finished
	input wire [1:0] nv_load_i, // stored settings, read at release
	output reg blk_rd_o, // request block byte fetch
	output reg blk_sel_o, // 0 values, 1 thresholds
	output reg [9:0] blk_idx_o, // byte index to fetch
	input wire [7:0] blk_byte_i, // fetched byte, valid with blk_rd_o
	input wire [8*N_ATTR-1:0] attr_val_i, // current attribute values
	input wire [8*N_ATTR-1:0] attr_thr_i, // thresholds
	input wire pm_enter_i, // pulse: power saving requested
	output reg pm_go_o, // pulse: power saving may proceed
	output reg pred_en_o, // prediction currently enabled
	output reg autosave_o // autosave currently enabled
);
	localparam S_IDLE = 8'h01;
	localparam S_SAVE = 8'h02;
	localparam S_NV = 8'h04;
	localparam S_FETCH = 8'h08;
	localparam S_XFER = 8'h10;
	localparam S_CMP = 8'h20;
	localparam S_DONE = 8'h40;
	localparam S_PMSAVE = 8'h80;
	// last byte index, cut to the index width on purpose
	localparam [31:0] LAST_FULL = BLOCK_BYTES - 1;
	localparam [9:0] LAST_IDX = LAST_FULL[9:0];

	// sequencer state, one-hot
	// idle waits for a command or a power-save request; save waits on the
	// medium; nv waits on the settings store; fetch and xfer move one block
	// byte each round; cmp writes the verdict; done ends every command and
	// raises the interrupt; pmsave is the automatic save before power saving
	reg [7:0] state;
	reg [7:0] features_subcommand;
	reg [7:0] sector_count_operand;
	reg [7:0] sector_number_reg;
	reg [7:0] cylinder_low_key;
	reg [7:0] cylinder_high_key;
	reg [7:0] drive_head_select;
	reg [7:0] fault_code;
	reg busy_flag;
	reg err_flag;
	reg drq_flag;
	// subcommand latched at command time, so later host writes cannot steer
	// a command already running
	reg [7:0] sub;
	// settings load pending after reset release
	reg loaded;
	wire crossed;
	wire cmd_wr;
	wire keys_ok;

	// any attribute at or below a nonzero threshold trips the verdict; the compare
	// is combinational and only consumed in the cmp state
	sfp_attr_cmp #(
		.N(N_ATTR)
	) u_cmp (
		.value_i(attr_val_i),
		.thresh_i(attr_thr_i),
		.crossed_o(crossed)
	);

	// command write decode and key test; keys are checked on every subcommand,
	// the enable one included, so a stray write cannot turn prediction on
	assign cmd_wr = wr_i && (addr_i == `SFP_ADDR_CMD);
	assign keys_ok = (cylinder_low_key == `SFP_KEY_LOW) && (cylinder_high_key == `SFP_KEY_HIGH);

	// read mux; condition flags assembled from live bits
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`SFP_ADDR_FEAT: rdata_o <= fault_code;
				`SFP_ADDR_SCNT: rdata_o <= sector_count_operand;
				`SFP_ADDR_SNUM: rdata_o <= sector_number_reg;
				`SFP_ADDR_CYLL: rdata_o <= cylinder_low_key;
				`SFP_ADDR_CYLH: rdata_o <= cylinder_high_key;
				`SFP_ADDR_DHS: rdata_o <= drive_head_select;
				`SFP_ADDR_CMD: rdata_o <= {busy_flag, !busy_flag, 2'b00, drq_flag, 2'b00, err_flag};
				default: rdata_o <= 8'h00;
			endcase
		end
	end

	// task-file registers; host writes are ignored while busy
	// the cylinder pair doubles as key input and verdict output; the verdict
	// write has priority and can only happen while busy, so the two never meet
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			features_subcommand <= 8'h00;
			sector_count_operand <= 8'h00;
			sector_number_reg <= 8'h00;
			cylinder_low_key <= 8'h00;
			cylinder_high_key <= 8'h00;
			drive_head_select <= 8'h00;
		end else if (state == S_CMP) begin
			if (crossed) begin
				cylinder_low_key <= `SFP_FAIL_LOW;
				cylinder_high_key <= `SFP_FAIL_HIGH;
			end else begin
				cylinder_low_key <= `SFP_KEY_LOW;
				cylinder_high_key <= `SFP_KEY_HIGH;
			end
		end else if (wr_i && !busy_flag) begin
			case (addr_i)
				`SFP_ADDR_FEAT: features_subcommand <= wdata_i;
				`SFP_ADDR_SCNT: sector_count_operand <= wdata_i;
				`SFP_ADDR_SNUM: sector_number_reg <= wdata_i;
				`SFP_ADDR_CYLL: cylinder_low_key <= wdata_i;
				`SFP_ADDR_CYLH: cylinder_high_key <= wdata_i;
				`SFP_ADDR_DHS: drive_head_select <= wdata_i;
				default: ;
			endcase
		end
	end

	// command sequencer
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= S_IDLE;
			sub <= 8'h00;
			busy_flag <= 1'b0;
			err_flag <= 1'b0;
			drq_flag <= 1'b0;
			fault_code <= 8'h00;
			irq_o <= 1'b0;
			save_req_o <= 1'b0;
			nv_wr_o <= 1'b0;
			nv_data_o <= 2'b00;
			blk_rd_o <= 1'b0;
			blk_sel_o <= 1'b0;
			blk_idx_o <= 10'h000;
			data_valid_o <= 1'b0;
			data_o <= 8'h00;
			pm_go_o <= 1'b0;
			pred_en_o <= 1'b0;
			autosave_o <= 1'b0;
			loaded <= 1'b0;
		end else begin
			// power-save grant is a single-cycle pulse
			pm_go_o <= 1'b0;
			// status read acknowledges the interrupt; a new completion wins
			if (rd_i && (addr_i == `SFP_ADDR_CMD) && state != S_DONE)
				irq_o <= 1'b0;
			// settings come back from nonvolatile store after release
			if (!loaded) begin
				loaded <= 1'b1;
				pred_en_o <= nv_load_i[0];
				autosave_o <= nv_load_i[1];
			end
			case (state)
				S_IDLE: begin
					if (cmd_wr && !busy_flag && wdata_i == `SFP_CMD_SMART) begin
						busy_flag <= 1'b1;
						err_flag <= 1'b0;
						fault_code <= 8'h00;
						sub <= features_subcommand;
						if (!keys_ok) begin
							state <= S_DONE;
							err_flag <= 1'b1;
							fault_code <= `SFP_FAULT_ABORT;
						end else if (!pred_en_o && features_subcommand != `SFP_SUB_ENABLE) begin
							state <= S_DONE;
							err_flag <= 1'b1;
							fault_code <= `SFP_FAULT_ABORT;
						end else begin
							case (features_subcommand)
								`SFP_SUB_RD_ATTR, `SFP_SUB_SAVE, `SFP_SUB_STATUS: begin
									save_req_o <= 1'b1;
									state <= S_SAVE;
								end
								`SFP_SUB_RD_THR: begin
									blk_sel_o <= 1'b1;
									blk_idx_o <= 10'h000;
									blk_rd_o <= 1'b1;
									state <= S_FETCH;
								end
								`SFP_SUB_AUTOSAVE: begin
									nv_data_o <= {sector_count_operand != 8'h00, pred_en_o};
									nv_wr_o <= 1'b1;
									state <= S_NV;
								end
								`SFP_SUB_ENABLE: begin
									nv_data_o <= {autosave_o, 1'b1};
									nv_wr_o <= 1'b1;
									state <= S_NV;
								end
								`SFP_SUB_DISABLE: begin
									nv_data_o <= {autosave_o, 1'b0};
									nv_wr_o <= 1'b1;
									state <= S_NV;
								end
								default: begin
									state <= S_DONE;
									err_flag <= 1'b1;
									fault_code <= `SFP_FAULT_ABORT;
								end
							endcase
						end
					end else if (pm_enter_i) begin
						// a power-save save is skipped with prediction off
						if (autosave_o && pred_en_o) begin
							save_req_o <= 1'b1;
							state <= S_PMSAVE;
						end else begin
							pm_go_o <= 1'b1;
						end
					end
				end
				// wait for the medium; status goes on to compare, a value read
				// goes on to the data phase, a plain save just finishes
				S_SAVE: begin
					if (save_done_i) begin
						save_req_o <= 1'b0;
						if (sub == `SFP_SUB_STATUS) begin
							state <= S_CMP;
						end else if (sub == `SFP_SUB_RD_ATTR) begin
							busy_flag <= 1'b0;
							blk_sel_o <= 1'b0;
							blk_idx_o <= 10'h000;
							blk_rd_o <= 1'b1;
							state <= S_FETCH;
						end else begin
							state <= S_DONE;
						end
					end
				end
				// the live settings change only once the store has accepted them,
				// so a reset during the write never leaves the two disagreeing
				S_NV: begin
					if (nv_done_i) begin
						nv_wr_o <= 1'b0;
						pred_en_o <= nv_data_o[0];
						autosave_o <= nv_data_o[1];
						state <= S_DONE;
					end
				end
				S_FETCH: begin
					// one-cycle fetch, byte presented until host ack
					blk_rd_o <= 1'b0;
					busy_flag <= 1'b0;
					drq_flag <= 1'b1;
					data_o <= blk_byte_i;
					data_valid_o <= 1'b1;
					state <= S_XFER;
				end
				// byte stands until acknowledged; no timeout, a silent host stalls
				// the block in the data phase until the next reset
				S_XFER: begin
					if (data_ack_i) begin
						data_valid_o <= 1'b0;
						if (blk_idx_o == LAST_IDX) begin
							drq_flag <= 1'b0;
							state <= S_DONE;
						end else begin
							blk_idx_o <= blk_idx_o + 10'h001;
							blk_rd_o <= 1'b1;
							state <= S_FETCH;
						end
					end
				end
				S_CMP: begin
					// verdict lands in the cylinder registers this cycle
					state <= S_DONE;
				end
				// automatic save ahead of power saving; busy stays low because no
				// host command is running
				S_PMSAVE: begin
					if (save_done_i) begin
						save_req_o <= 1'b0;
						pm_go_o <= 1'b1;
						state <= S_IDLE;
					end
				end
				// common exit: the interrupt rises; busy falls on the same edge unless a block read cleared it earlier
				S_DONE: begin
					busy_flag <= 1'b0;
					irq_o <= 1'b1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// ==== sim/sfp_cmd_properties.sv ====
// Purpose: port timing checks for the command block
// Assumes: one clock domain, reset low
// Notes: handshake waits are bounded by the partner
`timescale 1ns/100ps
module sfp_cmd_props (
	input wire clock_i, // clock
	input wire arst_n_i, // reset
	input wire rd_i, // read strobe
	input wire [9:0] addr_i, // address
	input wire [7:0] rdata_o, // read data
	input wire save_req_o, // save request
	input wire save_done_i, // save finished
	input wire nv_wr_o, // store request
	input wire [1:0] nv_data_o, // store data
	input wire nv_done_i, // store finished
	input wire pred_en_o, // prediction on
	input wire autosave_o, // autosave on
	input wire data_valid_o, // byte offered
	input wire [7:0] data_o, // byte
	input wire data_ack_i, // byte taken
	input wire blk_rd_o // fetch pulse
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);
	// a finished store write and a status read
	sequence s_nv_fin;
		nv_wr_o && nv_done_i;
	endsequence
	sequence s_stat_rd;
		rd_i && addr_i == 10'h01f7;
	endsequence
	chk_save_held:
	assert property (save_req_o && !save_done_i |=> save_req_o) else $error("save request dropped");
	chk_nv_held:
	assert property (nv_wr_o && !nv_done_i |=> nv_wr_o) else $error("store request dropped");
	chk_pred_update:
	assert property (s_nv_fin |=> pred_en_o == $past(nv_data_o[0])) else $error("prediction not updated");
	chk_autosave_update:
	assert property (s_nv_fin |=> autosave_o == $past(nv_data_o[1])) else $error("autosave not updated");
	chk_byte_held:
	assert property (data_valid_o && !data_ack_i |=> data_valid_o && $stable(data_o)) else $error("byte lost");
	chk_fetch_pulse:
	assert property (blk_rd_o |=> !blk_rd_o) else $error("fetch too long");
	chk_fetch_byte:
	assert property (blk_rd_o |-> ##[1:4] data_valid_o) else $error("fetch not offered");
	chk_ready_busy:
	assert property (s_stat_rd |=> rdata_o[6] != rdata_o[7]) else $error("ready equals busy");
endmodule

// ==== sim/sfp_media_model.sv ====
// Purpose: medium, settings store and block source
// Assumes: requests held until answered
// Notes: store survives design resets, like power cycles
`timescale 1ns/100ps
module sfp_media_model (
	input wire clock_i, // clock
	input wire slow_i, // long waits
	input wire save_req_i, // save request
	output reg save_done_o, // save pulse
	input wire nv_wr_i, // store request
	input wire [1:0] nv_data_i, // store data
	output reg nv_done_o, // store pulse
	output reg [1:0] nv_store_o, // kept settings
	input wire blk_rd_i, // fetch strobe
	input wire blk_sel_i, // block select
	input wire [9:0] blk_idx_i, // index
	output wire [7:0] blk_byte_o // fetched byte
);
	reg [3:0] wait_cnt;
	wire [7:0] byte_v;
	initial begin
		save_done_o = 1'b0;
		nv_done_o = 1'b0;
		nv_store_o = 2'h0;
		wait_cnt = 4'h0;
	end
	// one pulse per request; idle after answering
	always @(posedge clock_i) begin
		save_done_o <= 1'b0;
		nv_done_o <= 1'b0;
		if ((save_req_i || nv_wr_i) && !save_done_o && !nv_done_o) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt == (slow_i ? 4'h9 : 4'h1)) begin
				wait_cnt <= 4'h0;
				save_done_o <= save_req_i;
				nv_done_o <= nv_wr_i;
				if (nv_wr_i)
					nv_store_o <= nv_data_i;
			end
		end
	end
	// outside a fetch the byte is inverted, never stale
	assign byte_v = blk_idx_i[7:0] ^ {blk_sel_i, 6'h00, blk_idx_i[8]};
	assign blk_byte_o = blk_rd_i ? byte_v : ~byte_v;
endmodule

// ==== sim/sfp_cmd_bench.sv ====
// Purpose: self-checking bench for the command block
// Assumes: one-cycle strobes driven 1 ns after the edge
// Notes: rows hold sub, count, key, err, pred, autosave
`timescale 1ns/100ps
`include "sfp_defines.vh"
module sfp_cmd_bench;
	reg clock_i, arst_n_i, wr_i, rd_i, ack, pm_enter, slow, seen;
	reg [9:0] addr_i;
	reg [7:0] wdata_i, st, rv, sub;
	reg [239:0] val, thr;
	reg [35:0] rows [0:9];
	wire [7:0] rdata_o, data_o, bbyte;
	wire irq, dv, sreq, sdone, nvw, nvd, brd, bsel, pm_go, pred, asv;
	wire [1:0] nvdat, nvst;
	wire [9:0] bidx;
	integer miscompares, num_checks, i, n, cnt;
	sfp_cmd u_sfp_cmd (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq), .data_valid_o(dv), .data_o(data_o),
		.data_ack_i(ack), .save_req_o(sreq), .save_done_i(sdone), .nv_wr_o(nvw), .nv_data_o(nvdat),
		.nv_done_i(nvd), .nv_load_i(nvst), .blk_rd_o(brd), .blk_sel_o(bsel), .blk_idx_o(bidx),
		.blk_byte_i(bbyte), .attr_val_i(val), .attr_thr_i(thr), .pm_enter_i(pm_enter), .pm_go_o(pm_go),
		.pred_en_o(pred), .autosave_o(asv));
	sfp_media_model u_sfp_media_model (.clock_i(clock_i), .slow_i(slow), .save_req_i(sreq),
		.save_done_o(sdone), .nv_wr_i(nvw), .nv_data_i(nvdat), .nv_done_o(nvd), .nv_store_o(nvst),
		.blk_rd_i(brd), .blk_sel_i(bsel), .blk_idx_i(bidx), .blk_byte_o(bbyte));
	task check(input [15:0] got, input [15:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr(input [9:0] a, input [7:0] d);
		@(posedge clock_i);
		#1 {wr_i, addr_i, wdata_i} = {1'b1, a, d};
		@(posedge clock_i);
		#1 wr_i = 1'b0;
	endtask
	task rd(input [9:0] a);
		@(posedge clock_i);
		#1 {rd_i, addr_i} = {1'b1, a};
		@(posedge clock_i);
		#1 rd_i = 1'b0;
		rv = rdata_o;
	endtask
	// issue a command, take any data bytes, then read status
	task cmd(input [7:0] s, input [7:0] sc, input [7:0] key);
		sub = s;
		cnt = 0;
		wr(`SFP_ADDR_SCNT, sc);
		wr(`SFP_ADDR_CYLL, key);
		wr(`SFP_ADDR_CYLH, `SFP_KEY_HIGH);
		wr(`SFP_ADDR_FEAT, s);
		wr(`SFP_ADDR_CMD, `SFP_CMD_SMART);
		for (n = 0; n < 5000 && irq !== 1'b1; n = n + 1) begin
			@(posedge clock_i);
			#1;
			if (dv === 1'b1) begin
				check(data_o, bbyte_exp(cnt, s == `SFP_SUB_RD_THR));
				cnt = cnt + 1;
				ack = 1'b1;
				@(posedge clock_i);
				#1 ack = 1'b0;
			end
		end
		check(irq, 1'b1);
		rd(`SFP_ADDR_CMD);
		st = rv;
		check(st[7], 1'b0);
	endtask
	function [7:0] bbyte_exp(input [9:0] k, input s);
		bbyte_exp = k[7:0] ^ {s, 6'h00, k[8]};
	endfunction
	task reset_dut;
		arst_n_i = 1'b0;
		repeat (12) @(posedge clock_i);
		#1 arst_n_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1;
	endtask
	task power_save(input exp);
		seen = 1'b0;
		pm_enter = 1'b1;
		@(posedge clock_i);
		#1 pm_enter = 1'b0;
		for (n = 0; n < 200 && pm_go !== 1'b1; n = n + 1) @(posedge clock_i) #1;
		check(n < 200, 1'b1);
		check(seen, exp);
	endtask
	always @(posedge clock_i)
		if (sreq === 1'b1)
			seen <= 1'b1;
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		#200000;
		miscompares = miscompares + 1;
		test_done;
	end
	initial begin
		{arst_n_i, wr_i, rd_i, ack, pm_enter, slow, seen, addr_i, wdata_i} = 0;
		{miscompares, num_checks} = 0;
		val = {30{8'h50}};
		thr = {30{8'h10}};
		rows[0] = 36'hd_8004_e100;
		rows[1] = 36'hd_3004_f100;
		rows[2] = 36'hd_8004_f010;
		rows[3] = 36'hd_2014_f011;
		rows[4] = 36'hd_2004_f010;
		rows[5] = 36'hd_2ff4_f011;
		rows[6] = 36'hd_3004_f011;
		rows[7] = 36'h5_5004_f111;
		rows[8] = 36'hd_9004_f001;
		rows[9] = 36'hd_8004_f011;
		reset_dut;
		check({irq, pred, asv, sreq, nvw}, 5'h00);
		for (i = 0; i < 10; i = i + 1) begin
			slow = i[0];
			cmd(rows[i][35:28], rows[i][27:20], rows[i][19:12]);
			check(st[0], rows[i][11:8]);
			rd(`SFP_ADDR_FEAT);
			check(rv, rows[i][8] ? `SFP_FAULT_ABORT : 8'h00);
			check(pred, rows[i][7:4]);
			check(asv, rows[i][3:0]);
		end
		seen = 1'b0;
		cmd(`SFP_SUB_STATUS, 8'h00, `SFP_KEY_LOW);
		check(seen, 1'b1);
		rd(`SFP_ADDR_CYLL);
		check(rv, `SFP_KEY_LOW);
		rd(`SFP_ADDR_CYLH);
		check(rv, `SFP_KEY_HIGH);
		val[31:24] = 8'h10;
		cmd(`SFP_SUB_STATUS, 8'h00, `SFP_KEY_LOW);
		rd(`SFP_ADDR_CYLL);
		check(rv, `SFP_FAIL_LOW);
		rd(`SFP_ADDR_CYLH);
		check(rv, `SFP_FAIL_HIGH);
		seen = 1'b0;
		cmd(`SFP_SUB_RD_ATTR, 8'h00, `SFP_KEY_LOW);
		check({seen, cnt[9:0]}, 11'h600);
		cmd(`SFP_SUB_RD_THR, 8'h00, `SFP_KEY_LOW);
		check(cnt, 16'h0200);
		reset_dut;
		check({pred, asv}, 2'h3);
		power_save(1'b1);
		cmd(`SFP_SUB_DISABLE, 8'h00, `SFP_KEY_LOW);
		power_save(1'b0);
		reset_dut;
		check({pred, asv}, 2'h1);
		test_done;
	end
endmodule
bind sfp_cmd sfp_cmd_props u_sfp_cmd_props (.clock_i(clock_i), .arst_n_i(arst_n_i), .rd_i(rd_i),
	.addr_i(addr_i), .rdata_o(rdata_o), .save_req_o(save_req_o), .save_done_i(save_done_i),
	.nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o), .nv_done_i(nv_done_i), .pred_en_o(pred_en_o),
	.autosave_o(autosave_o), .data_valid_o(data_valid_o), .data_o(data_o), .data_ack_i(data_ack_i),
	.blk_rd_o(blk_rd_o));
